// file: include/cfg_word_pkg.sv
/*
 * Constants, field layout and carrier types for the boot protection
 * configuration word block.
 * Assumes a single pclk domain and an APB register bus of 32-bit data.
 */
// Function
// - Code-protect bit 28 low blocks external programmer
// - Boot write-protect bit 24 low blocks boot writes
// - Page field 19:12 is complement of count
// - All ones disables; lower codes protect upward
// - Scan-port enable copied into runtime control register
package cfg_word_pkg;

    // APB register byte offsets
    localparam logic [11:0] CFG_WORD_OFF = 12'h000;
    localparam logic [11:0] RUNTIME_CTRL_OFF = 12'h004;
    localparam logic [11:0] STATUS_OFF = 12'h008;
    localparam logic [11:0] CHECK_OFF = 12'h00C;

    // Word field positions
    localparam int RSVD_ZERO_BIT = 31;
    localparam int CODE_PROT_BIT = 28;
    localparam int BOOT_WP_BIT = 24;
    localparam int PAGE_HI_BIT = 19;
    localparam int PAGE_LO_BIT = 12;
    localparam int DBG_SEL_HI_BIT = 4;
    localparam int DBG_SEL_LO_BIT = 3;
    localparam int SCAN_EN_BIT = 2;

    // Reserved bits that must read as one, and the blank (erased) word
    localparam logic [31:0] RSVD_ONE_MASK = 32'h6EF0_0FE0;
    localparam logic [31:0] RSVD_ZERO_MASK = 32'h8000_0000;
    localparam logic [31:0] ERASED_WORD = 32'h7FFF_FFFF;

    // Program flash layout: 4 KiB pages from the flash base
    localparam logic [31:0] PFLASH_BASE = 32'hBD00_0000;
    localparam int PAGE_SHIFT = 12;
    localparam logic [7:0] PAGE_PROT_OFF = 8'hFF;

    // Runtime control register layout
    localparam int RT_SCAN_EN_BIT = 3;

    // Reset of latched word state: all protection on until loaded
    localparam logic [31:0] SAFE_WORD = 32'h0000_0000;

    // Decoded protection view of the word
    typedef struct packed {
        logic code_read_protect_n;
        logic boot_write_protect_n;
        logic [7:0] program_page_protect_count;
        logic [1:0] debug_channel_select;
        logic scan_port_enable;
    } cfg_fields_t;

    // Flash write request from the core side
    typedef struct packed {
        logic valid;
        logic boot;
        logic [31:0] addr;
    } flash_wr_t;

endpackage : cfg_word_pkg

// file: hw/page_limit.sv
/*
 * Turns the complemented page field into the top protected address
 * and compares a program flash address against it.
 * Assumes pages of 4 KiB starting at the program flash base.
 */
`timescale 1ns/10ps
`default_nettype none
module page_limit
    import cfg_word_pkg::*;
(
    // Field and probe address
    input wire logic [7:0] page_field,
    input wire logic [31:0] addr,
    // Result
    output logic enabled,
    output logic [31:0] limit,
    output logic hit
);
    logic [7:0] pages;

    // Complement gives the protected page count
    assign pages = ~page_field;
    assign enabled = (page_field != PAGE_PROT_OFF);
    // Limit is base plus count pages, minus one byte
    assign limit = PFLASH_BASE + ({24'h00_0000, pages} << PAGE_SHIFT) - 32'h0000_0001;
    assign hit = enabled && (addr >= PFLASH_BASE) && (addr <= limit);

endmodule : page_limit
`default_nettype wire

// file: hw/flash_protect_config_word.sv
/*
 * Boot protection configuration word: holds the word loaded from the
 * configuration flash row, applies code-read, boot write and program
 * page write protection, and seeds the scan-port enable of the runtime
 * control register. Software sees it all over APB.
 * Refusals leave sticky status flags that software clears by writing
 * ones; a refusal in the very cycle of its clear is kept.
 * Assumes cfg_word_in is stable while presetn is low and just after,
 * and that program/debug logic obeys the grant outputs.
 */
`timescale 1ns/10ps
`default_nettype none
module flash_protect_config_word
    import cfg_word_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Word as stored in configuration flash
    input wire logic [31:0] cfg_word_in,
    // External programmer access request
    input wire logic ext_prog_req,
    output logic ext_prog_grant,
    // Execution-time flash write request
    input wire flash_wr_t core_wr,
    output logic core_wr_grant,
    output logic core_wr_blocked,
    // Decoded configuration
    output cfg_fields_t fields,
    output logic scan_port_enable_rt
);
    // Held word, load flag and runtime state
    logic [31:0] word_reg;
    logic loaded_reg;
    logic scan_en_reg;
    logic [1:0] blocked_cnt_reg;
    logic prog_blocked_reg;
    logic boot_blocked_reg;
    logic page_blocked_reg;
    // Decode, bus and read helpers
    logic page_on;
    logic page_hit;
    logic setup;
    logic access;
    logic wr_en;
    logic rd_setup;
    logic addr_ok;
    logic wr_refused;
    logic status_wr;
    logic [2:0] status_clr;
    logic boot_refuse;
    logic page_refuse;
    logic core_refuse;
    logic rsvd_ok;
    logic [31:0] status_word;
    logic [31:0] rd_next;

    // Load once, on the first edge after reset release, then freeze;
    // async reset takes the all-protected constant so nothing leaks early;
    // the pin is ignored afterwards, so a glitch cannot reopen protection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_reg <= SAFE_WORD;
            loaded_reg <= 1'b0;
        end else if (!loaded_reg) begin
            word_reg <= cfg_word_in;
            loaded_reg <= 1'b1;
        end
    end

    // Field view of the held word; taken from the register, never the
    // pin, so consumers see the same value the gates use
    assign fields.code_read_protect_n = word_reg[CODE_PROT_BIT];
    assign fields.boot_write_protect_n = word_reg[BOOT_WP_BIT];
    assign fields.program_page_protect_count = word_reg[PAGE_HI_BIT:PAGE_LO_BIT];
    assign fields.debug_channel_select = word_reg[DBG_SEL_HI_BIT:DBG_SEL_LO_BIT];
    assign fields.scan_port_enable = word_reg[SCAN_EN_BIT];

    // Page comparator; its limit address is only needed inside it
    page_limit u_page_limit (
        .page_field(word_reg[PAGE_HI_BIT:PAGE_LO_BIT]),
        .addr(core_wr.addr),
        .enabled(page_on),
        .limit(),
        .hit(page_hit)
    );

    // Programmer gets nothing until the word is loaded and the code-read
    // protect bit is 1; the reset word keeps everything closed
    assign ext_prog_grant = ext_prog_req && loaded_reg && word_reg[CODE_PROT_BIT];

    // Execution-time writes: boot region by its write-protect bit,
    // program pages by the page field; all refused until the word is in
    assign boot_refuse = core_wr.boot && !word_reg[BOOT_WP_BIT];
    assign page_refuse = !core_wr.boot && page_hit;
    assign core_refuse = !loaded_reg || boot_refuse || page_refuse;
    assign core_wr_grant = core_wr.valid && !core_refuse;
    assign core_wr_blocked = core_wr.valid && core_refuse;

    // APB phases; zero wait states, so pready never stalls the master
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign pready = 1'b1;
    // Four word offsets decode; anything else is unmapped
    assign addr_ok = (paddr == CFG_WORD_OFF) || (paddr == RUNTIME_CTRL_OFF)
        || (paddr == STATUS_OFF) || (paddr == CHECK_OFF);
    assign wr_en = access && pwrite && addr_ok;
    // Read data is fetched in setup so it stands for the whole access phase
    assign rd_setup = setup && !pwrite;

    // Runtime control and status (write one to clear) take writes;
    // the word and the check register are read-only and refuse them
    assign wr_refused = pwrite && (paddr != RUNTIME_CTRL_OFF) && (paddr != STATUS_OFF);
    assign pslverr = access && (!addr_ok || wr_refused);

    // Status clear strobes, one per sticky flag, by write data bit
    assign status_wr = wr_en && (paddr == STATUS_OFF);
    assign status_clr = {3{status_wr}} & pwdata[2:0];

    // Scan-port enable seeded from the word, then software may change it;
    // only byte lane 0 carries the bit, other strobes are ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_en_reg <= 1'b0;
        end else if (!loaded_reg) begin
            scan_en_reg <= cfg_word_in[SCAN_EN_BIT];
        end else if (wr_en && paddr == RUNTIME_CTRL_OFF && pstrb[0]) begin
            scan_en_reg <= pwdata[RT_SCAN_EN_BIT];
        end
    end
    assign scan_port_enable_rt = scan_en_reg;

    // Programmer refusal flag; a refusal in the clear cycle wins, so
    // software never loses an attempt it has not yet seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_blocked_reg <= 1'b0;
        end else if (ext_prog_req && !ext_prog_grant) begin
            prog_blocked_reg <= 1'b1;
        end else if (status_clr[0]) begin
            prog_blocked_reg <= 1'b0;
        end
    end

    // Boot write refusal flag, same set-wins order
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_blocked_reg <= 1'b0;
        end else if (core_wr_blocked && core_wr.boot) begin
            boot_blocked_reg <= 1'b1;
        end else if (status_clr[1]) begin
            boot_blocked_reg <= 1'b0;
        end
    end

    // Page write refusal flag, same set-wins order
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_blocked_reg <= 1'b0;
        end else if (core_wr_blocked && !core_wr.boot) begin
            page_blocked_reg <= 1'b1;
        end else if (status_clr[2]) begin
            page_blocked_reg <= 1'b0;
        end
    end

    // Saturating count of core write refusals, for quick software sanity checks;
    // it stops at three rather than wrapping, so a burst never reads as none
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blocked_cnt_reg <= 2'b00;
        end else if (core_wr_blocked && blocked_cnt_reg != 2'b11) begin
            blocked_cnt_reg <= blocked_cnt_reg + 2'b01;
        end
    end

    // Status: flags in bits 2:0, then loaded, refusal count, page enable
    assign status_word = {24'h00_0000, page_on, blocked_cnt_reg, loaded_reg, 1'b0,
        page_blocked_reg, boot_blocked_reg, prog_blocked_reg};

    // Reserved-bit check of the stored word: ones where the layout wants
    // ones and a zero in the top bit; a badly programmed part shows here
    assign rsvd_ok = ((word_reg & RSVD_ONE_MASK) == RSVD_ONE_MASK)
        && ((word_reg & RSVD_ZERO_MASK) == 32'h0000_0000);

    // Read mux
    always_comb begin
        rd_next = 32'h0000_0000;
        unique case (paddr)
            CFG_WORD_OFF: rd_next = word_reg;
            RUNTIME_CTRL_OFF: rd_next[RT_SCAN_EN_BIT] = scan_en_reg;
            STATUS_OFF: rd_next = status_word;
            CHECK_OFF: rd_next[0] = rsvd_ok;
            default: rd_next = 32'h0000_0000;
        endcase
    end

    // Read data registered in the setup cycle, valid in the access phase
    // and standing until the next read setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= rd_next;
        end
    end

endmodule : flash_protect_config_word
`default_nettype wire

// file: test/cfg_word_asserts.sv
/* Checker of the configuration word block's protection outputs.
   Bound to the top module; sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module cfg_word_asserts
    import cfg_word_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Watched ports
    input wire logic ext_prog_req,
    input wire logic ext_prog_grant,
    input wire flash_wr_t core_wr,
    input wire logic core_wr_blocked,
    input wire cfg_fields_t fields,
    input wire logic scan_port_enable_rt,
    // Word at the pin, for the load check
    input wire logic [31:0] cfg_word_in
);
    logic [1:0] age_reg;
    logic [31:0] lim;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Edges since release; the word is only valid from the first one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_reg <= 2'h0;
        end else if (age_reg != 2'h3) begin
            age_reg <= age_reg + 2'h1;
        end
    end
    // Top protected address for the page field
    assign lim = PFLASH_BASE + {12'h000, ~fields.program_page_protect_count, 12'h000}
        - 32'h0000_0001;
    sequence s_loaded;
        age_reg == 2'h1;
    endsequence
    a_prog_gate: assert property (
        ext_prog_req && age_reg != 2'h0 |-> ext_prog_grant == fields.code_read_protect_n)
        else $error("programmer grant wrong");
    a_boot_gate: assert property (
        core_wr.valid && core_wr.boot |-> core_wr_blocked == !fields.boot_write_protect_n)
        else $error("boot write gate wrong");
    a_page_gate: assert property (
        core_wr.valid && !core_wr.boot |-> core_wr_blocked ==
        (fields.program_page_protect_count != 8'hFF && core_wr.addr >= PFLASH_BASE
        && core_wr.addr <= lim))
        else $error("page write gate wrong");
    a_fields_hold: assert property (age_reg >= 2'h2 |-> $stable(fields))
        else $error("fields changed while running");
    a_scan_seed: assert property (
        s_loaded |-> scan_port_enable_rt == fields.scan_port_enable)
        else $error("scan enable not seeded");
    a_word_load: assert property (
        s_loaded |-> fields == {$past(cfg_word_in[CODE_PROT_BIT]),
        $past(cfg_word_in[BOOT_WP_BIT]), $past(cfg_word_in[PAGE_HI_BIT:PAGE_LO_BIT]),
        $past(cfg_word_in[DBG_SEL_HI_BIT:DBG_SEL_LO_BIT]), $past(cfg_word_in[SCAN_EN_BIT])})
        else $error("word not latched at load");
endmodule : cfg_word_asserts
`default_nettype wire

// file: test/prog_model.sv
/* Model of the external programming device: shapes the word it
   writes into configuration flash. Assumes the bench gives raw values. */
`timescale 1ns/10ps
`default_nettype none
module prog_model
    import cfg_word_pkg::*;
(
    // Requested field values
    input wire logic [31:0] raw,
    // Word as written to flash
    output logic [31:0] word
);
    // Reserved bits forced, so random fields never break the layout
    assign word = (raw | RSVD_ONE_MASK) & ~RSVD_ZERO_MASK;
endmodule : prog_model
`default_nettype wire

// file: test/tb_top.sv
/* Self-checking bench of the configuration word block.
   Assumes the package, programmer model and checker compile first. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import cfg_word_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext_prog_req = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, raw = 32'h0000_0000, word, prdata, rd, lim;
    logic pready, pslverr, err, ext_prog_grant, core_wr_grant, core_wr_blocked, scan_rt;
    logic [7:0] pg;
    logic [7:0] corner [4] = '{8'hFF, 8'hFE, 8'h7F, 8'h00};
    flash_wr_t core_wr = '0;
    cfg_fields_t fields;
    int num_errors = 0, total_checks = 0, cycles = 0;
    always #2.5 pclk = ~pclk;
    prog_model u_prog_model (.raw(raw), .word(word));
    flash_protect_config_word u_flash_protect_config_word (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cfg_word_in(word), .ext_prog_req(ext_prog_req), .ext_prog_grant(ext_prog_grant),
        .core_wr(core_wr), .core_wr_grant(core_wr_grant), .core_wr_blocked(core_wr_blocked),
        .fields(fields), .scan_port_enable_rt(scan_rt));
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // One APB transfer, held until pready is seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk); // Idle edge keeps back-to-back calls from re-driving psel
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic core(input logic b, input logic [31:0] a, input logic blk);
        core_wr <= '{1'b1, b, a};
        @(posedge pclk);
        check("blocked", {31'h0, blk}, {31'h0, core_wr_blocked});
        check("grant", {31'h0, ~blk}, {31'h0, core_wr_grant});
    endtask : core
    // Status expected after one programmer try and the four core writes
    function automatic logic [31:0] exp_status(input logic [31:0] w, input logic [7:0] p);
        logic [1:0] n;
        n = 2'(!w[BOOT_WP_BIT]) + ((p != 8'hFF) ? 2'h2 : 2'h0);
        return {24'h00_0000, p != 8'hFF, n, 1'b1, 1'b0, p != 8'hFF, !w[BOOT_WP_BIT],
            !w[CODE_PROT_BIT]};
    endfunction : exp_status
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(32'h321a));
        for (int i = 0; i < 12; i++) begin
            pg = (i < 4) ? corner[i] : 8'($urandom());
            raw <= {$urandom()} & 32'hFFF0_0FFF | {12'h000, pg, 12'h000};
            presetn <= 1'b0;
            repeat (4) @(posedge pclk);
            presetn <= 1'b1;
            repeat (2) @(posedge pclk);
            apb(1'b0, CFG_WORD_OFF, 32'h0000_0000);
            check("word", word, rd);
            apb(1'b1, CFG_WORD_OFF, ~word);
            check("ro error", 32'h0000_0001, {31'h0, err});
            apb(1'b0, CFG_WORD_OFF, 32'h0000_0000);
            check("word kept", word, rd);
            apb(1'b0, 12'h010, 32'h0000_0000);
            check("unmapped", 32'h0000_0001, {31'h0, err});
            apb(1'b0, RUNTIME_CTRL_OFF, 32'h0000_0000);
            check("scan", {31'h0, word[SCAN_EN_BIT]}, {31'h0, rd[RT_SCAN_EN_BIT]});
            ext_prog_req <= 1'b1;
            @(posedge pclk);
            check("prog", {31'h0, word[CODE_PROT_BIT]}, {31'h0, ext_prog_grant});
            ext_prog_req <= 1'b0;
            core(1'b1, $urandom(), ~word[BOOT_WP_BIT]);
            lim = PFLASH_BASE + {12'h000, ~pg, 12'h000} - 32'h0000_0001;
            core(1'b0, PFLASH_BASE, pg != 8'hFF);
            core(1'b0, lim, pg != 8'hFF);
            core(1'b0, lim + 32'h0000_0001, 1'b0);
            core_wr <= '0;
            apb(1'b0, CHECK_OFF, 32'h0000_0000);
            check("reserved ok", 32'h0000_0001, rd);
            apb(1'b0, STATUS_OFF, 32'h0000_0000);
            check("status", exp_status(word, pg), rd);
            apb(1'b1, STATUS_OFF, 32'h0000_0007);
            check("clear error", 32'h0000_0000, {31'h0, err});
            apb(1'b0, STATUS_OFF, 32'h0000_0000);
            check("status cleared", exp_status(word, pg) & 32'hFFFF_FFF8, rd);
            apb(1'b1, RUNTIME_CTRL_OFF, {28'h000_0000, ~word[SCAN_EN_BIT], 3'h0});
            apb(1'b0, RUNTIME_CTRL_OFF, 32'h0000_0000);
            check("scan write", {31'h0, ~word[SCAN_EN_BIT]}, {31'h0, rd[RT_SCAN_EN_BIT]});
        end
        give_verdict();
    end
endmodule : tb_top
bind flash_protect_config_word cfg_word_asserts u_cfg_word_asserts (.pclk, .presetn,
    .ext_prog_req, .ext_prog_grant, .core_wr, .core_wr_blocked, .fields, .scan_port_enable_rt,
    .cfg_word_in);
`default_nettype wire
